// [verilog/draw_engine_color_format_regs.sv]
// colour, stretch height and format/location registers of the drawing engine
//
// Operation
// - foreground: index, 16-bit, or RGB bytes
// - background uses the same per-format layout
// - 12-bit stretch height, Y stretch only
// - format 00=8, 01=16, 10=32, 11=24bpp
// - overwrite bit lets offsets apply always
// - Y offset valid on overwrite or 11xx
// - X offset same condition, nonzero needs rotation
// - location 1111 linear, else X-Y width
// - X-Y origin top-left, linear from first pixel
`timescale 1ns/1ps
module draw_engine_color_format_regs
    import draw_regs_pkg::*;
(
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [draw_regs_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                      pwdata,
    input  wire logic [3:0]                       pstrb,
    output logic                                  pready,
    output logic [31:0]                           prdata,
    output logic                                  pslverr,
    output logic [1:0]                            pixel_format_field,
    output logic [2:0]                            bytes_per_pixel,
    output logic                                  linear_addressing,
    output logic                                  xy_addressing,
    output logic                                  pattern_overwrite_select,
    output logic                                  pattern_offsets_valid,
    output logic [2:0]                            pattern_start_x,
    output logic [2:0]                            pattern_start_y,
    output logic                                  pattern_rotate_needed,
    output logic [11:0]                           stretch_source_height,
    output logic                                  font_colours_inverse,
    output logic [7:0]                            fg_index,
    output logic [15:0]                           fg_word,
    output logic [7:0]                            fg_red,
    output logic [7:0]                            fg_green,
    output logic [7:0]                            fg_blue,
    output logic [7:0]                            bg_index,
    output logic [15:0]                           bg_word,
    output logic [7:0]                            bg_red,
    output logic [7:0]                            bg_green,
    output logic [7:0]                            bg_blue
);
    // software visible registers plus derived engine controls
    typedef struct packed {
        logic [COL_W-1:0] fg;
        logic [COL_W-1:0] bg;
        logic [HT_W-1:0]  ht;
        logic [15:0]      fmt;
        logic [2:0]       bpp;
        logic             lin;
        logic             pat_ok;
        logic [PAT_W-1:0] pat_x;
        logic [PAT_W-1:0] pat_y;
        logic             rot;
        logic             inv;
    } bank_t;

    bank_t st_r;
    bank_t st_nxt;

    reg_access_if acc ();

    // merged write with byte lanes and writable mask
    function automatic logic [31:0] merge_write(
        input logic [31:0] old_val,
        input logic [31:0] wdata,
        input logic [3:0]  strb,
        input logic [31:0] wmask
    );
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge_write = ((old_val & ~lanes) | (wdata & lanes)) & wmask;
    endfunction : merge_write

    // bytes occupied by one pixel in each format
    function automatic logic [2:0] pixel_bytes(input pixel_format_t pf);
        case (pf)
            PF_8BPP: begin
                pixel_bytes = 3'h1;
            end
            PF_16BPP: begin
                pixel_bytes = 3'h2;
            end
            PF_32BPP: begin
                pixel_bytes = 3'h4;
            end
            default: begin
                pixel_bytes = 3'h3;
            end
        endcase
    endfunction : pixel_bytes

    // background equals inverted foreground within the pixel width
    function automatic logic is_inverse(
        input pixel_format_t    pf,
        input logic [COL_W-1:0] fg,
        input logic [COL_W-1:0] bg
    );
        logic [COL_W-1:0] diff;
        diff = fg ^ bg;
        case (pf)
            PF_8BPP: begin
                is_inverse = (diff[7:0] == 8'hff);
            end
            PF_16BPP: begin
                is_inverse = (diff[15:0] == 16'hffff);
            end
            default: begin
                is_inverse = (diff == 24'hffffff);
            end
        endcase
    endfunction : is_inverse

    // apb front end
    apb_front u_front (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .pready  (pready),
        .prdata  (prdata),
        .pslverr (pslverr),
        .acc     (acc.bus)
    );

    // fields of the format register as currently held
    pixel_format_t    pf;
    logic [LOC_W-1:0] loc;
    logic             ovr;
    logic [PAT_W-1:0] raw_x;
    logic [PAT_W-1:0] raw_y;
    logic [31:0]      status;

    assign pf    = pixel_format_t'(st_r.fmt[FMT_PF_LSB +: 2]);
    assign loc   = st_r.fmt[FMT_LOC_LSB +: LOC_W];
    assign ovr   = st_r.fmt[FMT_OVR_BIT];
    assign raw_x = st_r.fmt[FMT_X_LSB +: PAT_W];
    assign raw_y = st_r.fmt[FMT_Y_LSB +: PAT_W];

    // read-only state word
    assign status = {26'h0000000, st_r.fmt[FMT_PF_LSB +: 2], st_r.rot, st_r.pat_ok, st_r.lin, st_r.inv};

    // address decode, unused bits return zero
    always_comb begin
        acc.hit   = 1'b1;
        acc.rdata = 32'h00000000;
        if (acc.idx == IDX_FG) begin
            acc.rdata = {8'h00, st_r.fg};
        end else if (acc.idx == IDX_BG) begin
            acc.rdata = {8'h00, st_r.bg};
        end else if (acc.idx == IDX_HT) begin
            acc.rdata = {20'h00000, st_r.ht};
        end else if (acc.idx == IDX_FMT) begin
            acc.rdata = {16'h0000, st_r.fmt};
        end else if (acc.idx == IDX_STAT) begin
            acc.rdata = status;
        end else begin
            acc.hit = 1'b0;
        end
    end

    // register writes and derived controls
    always_comb begin
        logic [31:0]      wv;
        logic [15:0]      fmt_v;
        logic [LOC_W-1:0] loc_v;
        logic             hi_lin;
        logic             lin_v;
        wv     = 32'h00000000;
        st_nxt = st_r;

        // colour, height and format registers
        if (acc.wr && acc.idx == IDX_FG) begin
            wv        = merge_write({8'h00, st_r.fg}, acc.wdata, acc.strb, COL_WMASK);
            st_nxt.fg = wv[COL_W-1:0];
        end else if (acc.wr && acc.idx == IDX_BG) begin
            wv        = merge_write({8'h00, st_r.bg}, acc.wdata, acc.strb, COL_WMASK);
            st_nxt.bg = wv[COL_W-1:0];
        end else if (acc.wr && acc.idx == IDX_HT) begin
            wv        = merge_write({20'h00000, st_r.ht}, acc.wdata, acc.strb, HT_WMASK);
            st_nxt.ht = wv[HT_W-1:0];
        end else if (acc.wr && acc.idx == IDX_FMT) begin
            wv         = merge_write({16'h0000, st_r.fmt}, acc.wdata, acc.strb, FMT_WMASK);
            st_nxt.fmt = wv[15:0];
        end

        // addressing mode from the location field
        fmt_v  = st_nxt.fmt;
        loc_v  = fmt_v[FMT_LOC_LSB +: LOC_W];
        lin_v  = (loc_v == LOC_LINEAR);
        hi_lin = (loc_v[LOC_W-1 -: 2] == LOC_HI_LIN);

        // pattern offsets count only when enabled
        st_nxt.lin    = lin_v;
        st_nxt.pat_ok = fmt_v[FMT_OVR_BIT] | hi_lin;
        st_nxt.pat_y  = st_nxt.pat_ok ? fmt_v[FMT_Y_LSB +: PAT_W] : 3'h0;
        st_nxt.pat_x  = st_nxt.pat_ok ? fmt_v[FMT_X_LSB +: PAT_W] : 3'h0;
        st_nxt.rot    = st_nxt.pat_ok & (fmt_v[FMT_X_LSB +: PAT_W] != 3'h0);

        // pixel size and font colour check
        st_nxt.bpp = pixel_bytes(pixel_format_t'(fmt_v[FMT_PF_LSB +: 2]));
        st_nxt.inv = is_inverse(pixel_format_t'(fmt_v[FMT_PF_LSB +: 2]), st_nxt.fg, st_nxt.bg);
    end

    // zero after reset, except bytes per pixel which loads 1 to match 8bpp, since the hardware value is undefined
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r     <= '0;
            st_r.fg  <= COL_RST;
            st_r.bg  <= COL_RST;
            st_r.ht  <= HT_RST;
            st_r.fmt <= FMT_RST;
            st_r.bpp <= 3'h1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // per format split of both colour registers
    logic [COL_W-1:0] col_src [2];
    colour_fields_t   col_out [2];

    assign col_src[0] = st_r.fg;
    assign col_src[1] = st_r.bg;

    generate
        for (genvar g = 0; g < 2; g++) begin : g_colour
            colour_unpack u_unpack (
                .pclk    (pclk),
                .presetn (presetn),
                .pf      (pf),
                .colour  (col_src[g]),
                .fields  (col_out[g])
            );
        end
    endgenerate

    // foreground fields
    assign fg_index = col_out[0].index;
    assign fg_word  = col_out[0].word;
    assign fg_red   = col_out[0].red;
    assign fg_green = col_out[0].green;
    assign fg_blue  = col_out[0].blue;

    // background fields
    assign bg_index = col_out[1].index;
    assign bg_word  = col_out[1].word;
    assign bg_red   = col_out[1].red;
    assign bg_green = col_out[1].green;
    assign bg_blue  = col_out[1].blue;

    // engine controls straight from flops
    assign pixel_format_field       = st_r.fmt[FMT_PF_LSB +: 2];
    assign bytes_per_pixel          = st_r.bpp;
    assign linear_addressing        = st_r.lin;
    assign xy_addressing            = ~st_r.lin;
    assign pattern_overwrite_select = ovr;
    assign pattern_offsets_valid    = st_r.pat_ok;
    assign pattern_start_x          = st_r.pat_x;
    assign pattern_start_y          = st_r.pat_y;
    assign pattern_rotate_needed    = st_r.rot;
    assign stretch_source_height    = st_r.ht;
    assign font_colours_inverse     = st_r.inv;

endmodule : draw_engine_color_format_regs

// [verilog/draw_regs_pkg.sv]
// constants and types for the drawing engine colour and format registers
package draw_regs_pkg;

    // apb geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 8;

    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_FG   = 8'h14;
    localparam logic [IDX_W-1:0] IDX_BG   = 8'h18;
    localparam logic [IDX_W-1:0] IDX_HT   = 8'h1c;
    localparam logic [IDX_W-1:0] IDX_FMT  = 8'h1e;
    localparam logic [IDX_W-1:0] IDX_STAT = 8'h30;

    // writable bits of each register, the rest read as zero
    localparam logic [31:0] COL_WMASK = 32'h00ffffff;
    localparam logic [31:0] HT_WMASK  = 32'h00000fff;
    localparam logic [31:0] FMT_WMASK = 32'h00007f3f;

    // colour field positions
    localparam int COL_RED_LSB = 16;
    localparam int COL_GRN_LSB = 8;
    localparam int COL_BLU_LSB = 0;
    localparam int COL_W       = 24;

    // format and location field positions
    localparam int FMT_OVR_BIT = 14;
    localparam int FMT_Y_LSB   = 11;
    localparam int FMT_X_LSB   = 8;
    localparam int FMT_PF_LSB  = 4;
    localparam int FMT_LOC_LSB = 0;
    localparam int HT_W        = 12;
    localparam int PAT_W       = 3;
    localparam int LOC_W       = 4;

    localparam logic [LOC_W-1:0] LOC_LINEAR = 4'hf;
    localparam logic [1:0]       LOC_HI_LIN = 2'h3;

    // values after reset
    localparam logic [COL_W-1:0] COL_RST = 24'h000000;
    localparam logic [HT_W-1:0]  HT_RST  = 12'h000;
    localparam logic [15:0]      FMT_RST = 16'h0000;

    // pixel format field encodings in order 00, 01, 10, 11
    typedef enum logic [1:0] {
        PF_8BPP,
        PF_16BPP,
        PF_32BPP,
        PF_24BPP
    } pixel_format_t;

    // colour split by format
    typedef struct packed {
        logic [7:0]  index;
        logic [15:0] word;
        logic [7:0]  red;
        logic [7:0]  green;
        logic [7:0]  blue;
    } colour_fields_t;

endpackage : draw_regs_pkg

// [verilog/reg_access_if.sv]
// register access carrier between the apb front end and the register bank
`timescale 1ns/1ps
interface reg_access_if;
    import draw_regs_pkg::*;

    logic             rd;
    logic             wr;
    logic [IDX_W-1:0] idx;
    logic [31:0]      wdata;
    logic [3:0]       strb;
    logic [31:0]      rdata;
    logic             hit;

    modport bus  (output rd, output wr, output idx, output wdata, output strb, input rdata, input hit);
    modport regs (input rd, input wr, input idx, input wdata, input strb, output rdata, output hit);
endinterface : reg_access_if

// [verilog/apb_front.sv]
// apb slave front end: zero wait states, error on unmapped or unaligned address
`timescale 1ns/1ps
module apb_front
    import draw_regs_pkg::*;
(
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [draw_regs_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                     pwdata,
    input  wire logic [3:0]                      pstrb,
    output logic                                 pready,
    output logic [31:0]                          prdata,
    output logic                                 pslverr,
    reg_access_if.bus                            acc
);
    typedef struct packed {
        logic [31:0] rdata;
        logic        err;
    } front_t;

    front_t st_r;
    front_t st_nxt;
    logic   setup;
    logic   bad;

    // decode index and phase
    assign setup     = psel & ~penable;
    assign acc.idx   = paddr[IDX_W+1:2];
    assign acc.wdata = pwdata;
    assign acc.strb  = pstrb;
    assign bad       = ~acc.hit | (paddr[1:0] != 2'h0) | (paddr[ADDR_W-1:IDX_W+2] != '0);
    assign acc.rd    = setup & ~pwrite;
    assign acc.wr    = psel & penable & pwrite & ~st_r.err;

    // capture answer during setup
    always_comb begin
        st_nxt = st_r;
        if (setup) begin
            st_nxt.err   = bad;
            st_nxt.rdata = (bad | pwrite) ? 32'h00000000 : acc.rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pready  = 1'b1;
    assign prdata  = st_r.rdata;
    assign pslverr = psel & penable & st_r.err;
endmodule : apb_front

// [verilog/colour_unpack.sv]
// splits one colour register into its per format fields
`timescale 1ns/1ps
module colour_unpack
    import draw_regs_pkg::*;
(
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    input  wire draw_regs_pkg::pixel_format_t        pf,
    input  wire logic [draw_regs_pkg::COL_W-1:0]     colour,
    output draw_regs_pkg::colour_fields_t            fields
);
    colour_fields_t st_r;
    colour_fields_t st_nxt;

    // only the fields of the active format carry a value
    always_comb begin
        st_nxt = '0;
        case (pf)
            PF_8BPP: begin
                st_nxt.index = colour[7:0];
            end
            PF_16BPP: begin
                st_nxt.word = colour[15:0];
            end
            default: begin
                st_nxt.red   = colour[COL_RED_LSB +: 8];
                st_nxt.green = colour[COL_GRN_LSB +: 8];
                st_nxt.blue  = colour[COL_BLU_LSB +: 8];
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign fields = st_r;
endmodule : colour_unpack

// [sim/draw_regs_chk.sv]
// concurrent checks on the colour and format register block ports
`timescale 1ns/1ps
module draw_regs_chk (
    input wire logic                             pclk,
    input wire logic                             presetn,
    input wire logic                             psel,
    input wire logic                             penable,
    input wire logic                             pwrite,
    input wire logic [draw_regs_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                      pwdata,
    input wire logic [3:0]                       pstrb,
    input wire logic                             pready,
    input wire logic [1:0]                       pixel_format_field,
    input wire logic [2:0]                       bytes_per_pixel,
    input wire logic                             linear_addressing,
    input wire logic                             xy_addressing,
    input wire logic                             pattern_overwrite_select,
    input wire logic                             pattern_offsets_valid,
    input wire logic [2:0]                       pattern_start_x,
    input wire logic [2:0]                       pattern_start_y,
    input wire logic                             pattern_rotate_needed,
    input wire logic [11:0]                      stretch_source_height,
    input wire logic [15:0]                      fg_word,
    input wire logic [7:0]                       fg_red,
    input wire logic [7:0]                       bg_index,
    input wire logic [7:0]                       bg_green
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_bpp_map : assert property (
        bytes_per_pixel == (pixel_format_field == 2'h0 ? 3'h1 : pixel_format_field == 2'h1 ? 3'h2 :
                            pixel_format_field == 2'h2 ? 3'h4 : 3'h3))
        else $error("bytes per pixel does not match format");
    chk_addr_mode : assert property (
        linear_addressing != xy_addressing)
        else $error("linear and xy addressing not exclusive");
    chk_overwrite_valid : assert property (
        (pattern_overwrite_select || linear_addressing) |-> pattern_offsets_valid)
        else $error("pattern offsets not valid under overwrite or linear");
    chk_offsets_ignored : assert property (
        !pattern_offsets_valid |-> (pattern_start_x == 3'h0 && pattern_start_y == 3'h0))
        else $error("pattern offsets used while not valid");
    chk_rotate_flag : assert property (
        pattern_rotate_needed == (pattern_offsets_valid && pattern_start_x != 3'h0))
        else $error("rotate flag wrong");
    chk_fg_index_mode : assert property (
        ($past(pixel_format_field) == 2'h0 && pixel_format_field == 2'h0) |-> (fg_word == 16'h0 && fg_red == 8'h0))
        else $error("foreground wide fields set in 8 bit mode");
    chk_bg_word_mode : assert property (
        ($past(pixel_format_field) == 2'h1 && pixel_format_field == 2'h1) |-> (bg_index == 8'h0 && bg_green == 8'h0))
        else $error("background index or rgb set in 16 bit mode");
    chk_height_write : assert property (
        (psel && penable && pwrite && pready && paddr == 12'h070 && pstrb == 4'hf)
        |=> ({20'h0, stretch_source_height} == ($past(pwdata) & 32'h00000fff)))
        else $error("stretch height not taken from write");
endmodule : draw_regs_chk

bind draw_engine_color_format_regs draw_regs_chk chk_i (.*);

// [sim/apb_host.sv]
// apb master model of the software that programs the block
`timescale 1ns/1ps
module apb_host (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb
);
    // bus idle until software writes every field it uses
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end

    // one setup cycle, then access held until pready
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // font setup: background is the inverse of foreground
    // the colour compare register sits outside this block; this task writes only foreground and background
    task automatic load_font(input logic [23:0] c);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, 12'h050, {8'h0, c}, 4'hf, r, e);
        xfer(1'b1, 12'h060, {8'h0, ~c}, 4'hf, r, e);
    endtask : load_font
endmodule : apb_host

// [sim/testbench.sv]
// self-checking bench for the colour and format register block
`timescale 1ns/1ps
module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, stretch_source_height;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [1:0]  pixel_format_field;
    logic [2:0]  bytes_per_pixel, pattern_start_x, pattern_start_y;
    logic        linear_addressing, xy_addressing, pattern_overwrite_select;
    logic        pattern_offsets_valid, pattern_rotate_needed, font_colours_inverse;
    logic [7:0]  fg_index, fg_red, fg_green, fg_blue, bg_index, bg_red, bg_green, bg_blue;
    logic [15:0] fg_word, bg_word;
    int          failures = 0;
    int          tests_run = 0;

    draw_engine_color_format_regs uut (.*);
    apb_host host (.*);

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h got %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        host.xfer(1'b1, a, d, 4'hf, r, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        host.xfer(1'b0, a, 32'h0, 4'h0, r, e);
    endtask : rd

    // let controls and colour fields land
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask : settle

    // reserved bits ignore writes, lanes merge
    task automatic t_masks;
        logic [11:0] adr [4] = '{12'h050, 12'h060, 12'h070, 12'h078};
        logic [31:0] msk [4] = '{32'h00ffffff, 32'h00ffffff, 32'h00000fff, 32'h00007f3f};
        logic [31:0] r;
        logic        e;
        for (int i = 0; i < 4; i++) begin
            wr(adr[i], 32'hffffffff);
            rd(adr[i], r);
            chk("readback", msk[i], r);
        end
        settle();
        chk("height", 32'hfff, stretch_source_height);
        wr(12'h050, 32'h00123456);
        host.xfer(1'b1, 12'h050, 32'hffffabff, 4'h2, r, e);
        rd(12'h050, r);
        chk("lane merge", 32'h0012ab56, r);
    endtask : t_masks

    // colour split for every pixel format
    task automatic t_colours;
        logic [23:0] f = 24'hc3b2a1;
        logic [23:0] b = 24'h172839;
        logic [2:0]  bpp [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
        wr(12'h050, {8'h0, f});
        wr(12'h060, {8'h0, b});
        for (int p = 0; p < 4; p++) begin
            wr(12'h078, 32'(p) << 4);
            settle();
            chk("format", p, pixel_format_field);
            chk("bpp", bpp[p], bytes_per_pixel);
            chk("fg_index", p == 0 ? f[7:0] : 8'h0, fg_index);
            chk("fg_word", p == 1 ? f[15:0] : 16'h0, fg_word);
            chk("fg_red", p >= 2 ? f[23:16] : 8'h0, fg_red);
            chk("fg_green", p >= 2 ? f[15:8] : 8'h0, fg_green);
            chk("fg_blue", p >= 2 ? f[7:0] : 8'h0, fg_blue);
            chk("bg_index", p == 0 ? b[7:0] : 8'h0, bg_index);
            chk("bg_word", p == 1 ? b[15:0] : 16'h0, bg_word);
            chk("bg_red", p >= 2 ? b[23:16] : 8'h0, bg_red);
            chk("bg_blue", p >= 2 ? b[7:0] : 8'h0, bg_blue);
        end
    endtask : t_colours

    // inverse colours for font drawing, 24 then 8 bit width
    task automatic t_font;
        host.load_font(24'h5a0f96);
        settle();
        chk("inverse 24", 1, font_colours_inverse);
        wr(12'h060, 32'h00a5f068);
        settle();
        chk("not inverse", 0, font_colours_inverse);
        wr(12'h078, 32'h0);
        wr(12'h060, 32'h00000069);
        settle();
        chk("inverse 8", 1, font_colours_inverse);
    endtask : t_font

    // pattern offsets and addressing modes
    task automatic t_pattern;
        logic [15:0] v [4] = '{16'h3a0f, 16'h3a05, 16'h7a05, 16'h380c};
        logic        ok;
        for (int i = 0; i < 4; i++) begin
            ok = v[i][14] || v[i][3:2] == 2'h3;
            wr(12'h078, {16'h0, v[i]});
            settle();
            chk("linear", v[i][3:0] == 4'hf, linear_addressing);
            chk("xy", v[i][3:0] != 4'hf, xy_addressing);
            chk("overwrite", v[i][14], pattern_overwrite_select);
            chk("valid", ok, pattern_offsets_valid);
            chk("start_y", ok ? v[i][13:11] : 3'h0, pattern_start_y);
            chk("start_x", ok ? v[i][10:8] : 3'h0, pattern_start_x);
            chk("rotate", ok && v[i][10:8] != 3'h0, pattern_rotate_needed);
        end
    endtask : t_pattern

    // unmapped and unaligned accesses are refused
    task automatic t_refused;
        logic [31:0] r;
        logic        e;
        host.xfer(1'b1, 12'h100, 32'h1, 4'hf, r, e);
        chk("unmapped err", 1, e);
        host.xfer(1'b0, 12'h052, 32'h0, 4'h0, r, e);
        chk("unaligned err", 1, e);
        chk("unaligned data", 0, r);
    endtask : t_refused

    task automatic wrap_up;
        $display("Checks %0d, errors %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        chk("bpp reset", 1, bytes_per_pixel);
        chk("pready", 1, pready);
        t_masks();
        t_colours();
        t_font();
        t_pattern();
        t_refused();
        wrap_up();
    end

    // watchdog
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
endmodule : testbench
